// file: logic/brake_lowside_vds_supervisor.sv
// Low-side brake control with drain-source supervision while braking
// --------------------------------------------------------------------
// Notes on behaviour
// - Slam enabled and trigger high turns low sides on, charge pump off.
// - Parking brake enabled in sleep or stop turns low sides on, pump off.
// - Overvoltage brake on supply excess turns low sides on in every state.
// - Braking VDS threshold chosen by select bit: 0 first, 1 second.
// - Blank time starts with brake activation; select 0 first, 1 second.
// - VDS overvoltage ignored while brake blank time runs.
// - VDS overvoltage reported only after persisting the brake filter time.
// - Confirmed fault latches all low sides off; control bits untouched.
// - Fault sets the per-low-side brake fault status bit.
// - Low sides stay off until all brake fault bits are cleared.
// - Pump enable accepted but pump held off while any fault bit set.
// - Overvoltage braking active whenever its enable is set.
// - Supply above selected level turns all low sides on promptly.
// - Each supply causing overvoltage braking latches its own status bit.
// - Both supplies below hysteresis for filter time end overvoltage brake.
// - VDS fault during overvoltage braking turns all low sides off.
// --------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module brake_lowside_vds_supervisor #(
  parameter int LS_N = brake_pkg::LS_COUNT
) (
  input  wire logic            REF_CLK,
  input  wire logic            RST,
  input  wire logic            SLAM_ENABLE,
  input  wire logic            SLAM_TRIGGER_INPUT,
  input  wire logic [LS_N-1:0] SLAM_LOWSIDE_DISABLE,
  input  wire logic            PARKING_BRAKE_ENABLE,
  input  wire logic            SLEEP_OR_STOP,
  input  wire logic            OVERVOLTAGE_BRAKE_ENABLE,
  input  wire logic [2:0]      OV_LEVEL_SELECT,
  input  wire logic            MAIN_SUPPLY_OVER,
  input  wire logic            INTERNAL_SUPPLY_OVER,
  input  wire logic            MAIN_SUPPLY_BELOW_HYS,
  input  wire logic            INTERNAL_SUPPLY_BELOW_HYS,
  input  wire logic            BRAKE_VDS_THRESHOLD_SELECT,
  input  wire logic            BRAKE_BLANK_TIME_SELECT,
  input  wire logic [LS_N-1:0] VDS_OVER_TH_ONE,
  input  wire logic [LS_N-1:0] VDS_OVER_TH_TWO,
  input  wire logic [LS_N-1:0] FAULT_CLEAR,
  input  wire logic [1:0]      OVBRAKE_STATUS_CLEAR,
  input  wire logic            CHARGE_PUMP_ENABLE,
  output var  logic [LS_N-1:0] LOWSIDE_ON,
  output var  logic            CHARGE_PUMP_ON,
  output var  logic            BRAKE_ACTIVE,
  output var  logic [LS_N-1:0] LOWSIDE_BRAKE_VDS_FAULT,
  output var  logic            MAIN_SUPPLY_OVBRAKE_STATUS,
  output var  logic            INTERNAL_SUPPLY_OVBRAKE_STATUS,
  output var  logic [2:0]      OV_LEVEL_CODE
);

  localparam int TW = brake_pkg::TIMER_W;

  generate
    if (LS_N < 1 || LS_N > 8) begin : g_bad
      $error("brake supervisor: LS_N must be 1 to 8");
    end
  endgenerate

  // ------------------------------------------------------------------
  // State and internal signals
  // ------------------------------------------------------------------
  brake_pkg::brake_state_t state_reg;
  brake_pkg::brake_state_t state_next;
  logic [TW-1:0]   blank_cnt_reg;
  logic [LS_N-1:0] fault_reg;
  logic [LS_N-1:0] fault_next;
  logic [LS_N-1:0] lowside_on_reg;
  logic [LS_N-1:0] lowside_on_next;
  logic [LS_N-1:0] vds_sel;
  logic [LS_N-1:0] vds_hit;
  logic [1:0]      ovstat_reg;
  logic            ov_active_reg;
  logic            ov_set;
  logic            ov_release;
  logic            slam_req;
  logic            park_req;
  logic            brake_req;
  logic            cp_on_reg;
  logic            ov_brake;
  logic            brake_active_reg;
  logic [TW-1:0]   mon_age_reg;
  logic [TW-1:0]   hys_age_reg;

  // Threshold choice is a mux of the two comparator banks
  function automatic logic [LS_N-1:0] pick_th(
    input logic            sel,
    input logic [LS_N-1:0] th_one,
    input logic [LS_N-1:0] th_two
  );
    pick_th = (sel == brake_pkg::SEL_FIRST) ? th_one : th_two;
  endfunction

  // ------------------------------------------------------------------
  // Brake sources
  // ------------------------------------------------------------------
  assign slam_req  = SLAM_ENABLE && SLAM_TRIGGER_INPUT;
  assign park_req  = PARKING_BRAKE_ENABLE && SLEEP_OR_STOP;
  assign ov_set    = OVERVOLTAGE_BRAKE_ENABLE &&
                     (MAIN_SUPPLY_OVER || INTERNAL_SUPPLY_OVER);
  // A new excess brakes at once; a release or disable ends it at once
  assign ov_brake  = ov_set || (OVERVOLTAGE_BRAKE_ENABLE && ov_active_reg && !ov_release);
  assign brake_req = slam_req || park_req || ov_brake;
  assign vds_sel   = pick_th(BRAKE_VDS_THRESHOLD_SELECT,
                             VDS_OVER_TH_ONE, VDS_OVER_TH_TWO);

  // Release filter: both supplies below hysteresis for the filter time
  persist_filter #(
    .COUNT   (brake_pkg::OV_FILTER_CYC),
    .COUNT_W (TW)
  ) u_ov_release (
    .clk    (REF_CLK),
    .rst    (RST),
    .enable (ov_active_reg && !ov_set),
    .cond   (MAIN_SUPPLY_BELOW_HYS && INTERNAL_SUPPLY_BELOW_HYS),
    .hit    (ov_release)
  );

  // Overvoltage brake holds until released or disabled
  always_ff @(posedge REF_CLK) begin
    if (RST || !OVERVOLTAGE_BRAKE_ENABLE) begin
      ov_active_reg <= 1'b0;
    end else if (ov_set) begin
      ov_active_reg <= 1'b1;
    end else if (ov_release) begin
      ov_active_reg <= 1'b0;
    end
  end

  // Per-supply status; a new cause wins over a clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ovstat_reg <= 2'h0;
    end else begin
      ovstat_reg[0] <= (ovstat_reg[0] && !OVBRAKE_STATUS_CLEAR[0]) ||
                       (OVERVOLTAGE_BRAKE_ENABLE && MAIN_SUPPLY_OVER);
      ovstat_reg[1] <= (ovstat_reg[1] && !OVBRAKE_STATUS_CLEAR[1]) ||
                       (OVERVOLTAGE_BRAKE_ENABLE && INTERNAL_SUPPLY_OVER);
    end
  end

  // ------------------------------------------------------------------
  // VDS filters, one per low side
  // ------------------------------------------------------------------
  // Filters only run after blanking and on a driven low side
  genvar gi;
  generate
    for (gi = 0; gi < LS_N; gi++) begin : g_vds
      persist_filter #(
        .COUNT   (brake_pkg::VDS_FILTER_CYC),
        .COUNT_W (TW)
      ) u_vds (
        .clk    (REF_CLK),
        .rst    (RST),
        .enable (state_reg == brake_pkg::ST_MONITOR && lowside_on_reg[gi]),
        .cond   (vds_sel[gi]),
        .hit    (vds_hit[gi])
      );
    end
  endgenerate

  // Sticky fault bits; detection wins over a same-cycle clear
  assign fault_next = (fault_reg & ~FAULT_CLEAR) | vds_hit;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // ------------------------------------------------------------------
  // Brake sequencer
  // ------------------------------------------------------------------
  // Any fault, old or new, forces idle so low sides drop together
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      brake_pkg::ST_IDLE: begin
        if (brake_req && fault_next == '0) begin
          state_next = brake_pkg::ST_BLANK;
        end
      end
      brake_pkg::ST_BLANK: begin
        if (!brake_req || fault_next != '0) begin
          state_next = brake_pkg::ST_IDLE;
        end else if (blank_cnt_reg == '0) begin
          state_next = brake_pkg::ST_MONITOR;
        end
      end
      brake_pkg::ST_MONITOR: begin
        if (!brake_req || fault_next != '0) begin
          state_next = brake_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = brake_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= brake_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Blank timer loads on entry; BLANK lasts exactly the chosen count
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      blank_cnt_reg <= '0;
    end else if (state_reg == brake_pkg::ST_IDLE) begin
      blank_cnt_reg <= BRAKE_BLANK_TIME_SELECT ?
                       TW'(brake_pkg::BLANK_TWO_CYC - 1) :
                       TW'(brake_pkg::BLANK_ONE_CYC - 1);
    end else if (blank_cnt_reg != '0) begin
      blank_cnt_reg <= blank_cnt_reg - TW'(1);
    end
  end

  // ------------------------------------------------------------------
  // Drive outputs
  // ------------------------------------------------------------------
  // Slam-only braking honours per-side disables; other sources drive all
  always_comb begin
    lowside_on_next = '0;
    if (state_next != brake_pkg::ST_IDLE) begin
      lowside_on_next = '1;
      if (slam_req && !park_req && !ov_brake) begin
        lowside_on_next = ~SLAM_LOWSIDE_DISABLE;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      lowside_on_reg <= '0;
    end else begin
      lowside_on_reg <= lowside_on_next;
    end
  end

  // Pump request is kept but gated by braking and latched faults
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cp_on_reg <= 1'b0;
    end else begin
      cp_on_reg <= CHARGE_PUMP_ENABLE && fault_next == '0 &&
                   state_next == brake_pkg::ST_IDLE;
    end
  end

  // Brake flag registered from the next state, so it tracks the sequencer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      brake_active_reg <= 1'b0;
    end else begin
      brake_active_reg <= state_next != brake_pkg::ST_IDLE;
    end
  end

  // Level code to the analog comparators, registered for a clean output
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      OV_LEVEL_CODE <= brake_pkg::OV_LEVEL_RESET;
    end else begin
      OV_LEVEL_CODE <= OV_LEVEL_SELECT;
    end
  end

  assign LOWSIDE_ON                     = lowside_on_reg;
  assign CHARGE_PUMP_ON                 = cp_on_reg;
  assign BRAKE_ACTIVE                   = brake_active_reg;
  assign LOWSIDE_BRAKE_VDS_FAULT        = fault_reg;
  assign MAIN_SUPPLY_OVBRAKE_STATUS     = ovstat_reg[0];
  assign INTERNAL_SUPPLY_OVBRAKE_STATUS = ovstat_reg[1];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Checker helpers: run lengths of monitoring and of supply release
  // Both saturate, so a long stretch cannot wrap them back to small values
  always_ff @(posedge REF_CLK) begin
    if (RST || state_reg != brake_pkg::ST_MONITOR) begin
      mon_age_reg <= '0;
    end else if (mon_age_reg != '1) begin
      mon_age_reg <= mon_age_reg + TW'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || !ov_active_reg || ov_set ||
        !(MAIN_SUPPLY_BELOW_HYS && INTERNAL_SUPPLY_BELOW_HYS)) begin
      hys_age_reg <= '0;
    end else if (hys_age_reg != '1) begin
      hys_age_reg <= hys_age_reg + TW'(1);
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_fault_off: assert property (fault_reg != '0 |-> lowside_on_reg == '0)
    else $error("low side on while a brake fault is latched");
  a_fault_hold: assert property (
    fault_reg != '0 |=> ($past(fault_reg & ~FAULT_CLEAR) & ~fault_reg) == '0)
    else $error("brake fault bit dropped without a clear");
  a_pump_gate: assert property (fault_reg != '0 |-> !cp_on_reg)
    else $error("charge pump on while a brake fault is latched");
  a_slam_brake: assert property (
    slam_req && fault_next == '0 && state_reg == brake_pkg::ST_IDLE
    |=> state_reg == brake_pkg::ST_BLANK && !cp_on_reg)
    else $error("slam request did not start braking");
  a_park_brake: assert property (
    park_req && fault_next == '0 |=> state_reg != brake_pkg::ST_IDLE)
    else $error("parking request did not brake");
  a_ov_brake: assert property (
    ov_set && fault_next == '0 |=> lowside_on_reg == '1 ##0 ov_active_reg)
    else $error("overvoltage did not switch all low sides on");
  a_blank_mask: assert property (
    (fault_reg & ~$past(fault_reg)) != '0
    |-> $past(state_reg) == brake_pkg::ST_MONITOR)
    else $error("fault raised outside the monitor phase");
  a_filter_held: assert property (
    (fault_reg & ~$past(fault_reg)) != '0
    |-> (fault_reg & ~$past(fault_reg) & ~($past(vds_sel, 1) & $past(vds_sel, 2))) == '0)
    else $error("fault raised without a held VDS condition");
  a_filter_len: assert property (
    (fault_reg & ~$past(fault_reg)) != '0
    |-> $past(mon_age_reg) >= TW'(brake_pkg::VDS_FILTER_CYC - 1))
    else $error("fault raised before the filter time ran out");
  a_blank_len: assert property (
    state_reg == brake_pkg::ST_IDLE ##1 state_reg == brake_pkg::ST_BLANK
    && !BRAKE_BLANK_TIME_SELECT && $past(!BRAKE_BLANK_TIME_SELECT)
    |-> blank_cnt_reg == TW'(brake_pkg::BLANK_ONE_CYC - 1))
    else $error("blank timer loaded with the wrong count");
  a_ovstat_set: assert property (
    OVERVOLTAGE_BRAKE_ENABLE && INTERNAL_SUPPLY_OVER |=> ovstat_reg[1])
    else $error("internal supply status not latched");
  a_ov_release: assert property (
    $fell(ov_active_reg) && $past(OVERVOLTAGE_BRAKE_ENABLE)
    |-> $past(MAIN_SUPPLY_BELOW_HYS && INTERNAL_SUPPLY_BELOW_HYS))
    else $error("overvoltage brake ended without both supplies low");
  a_ov_filter: assert property (
    $fell(ov_active_reg) && $past(OVERVOLTAGE_BRAKE_ENABLE)
    |-> $past(hys_age_reg) >= TW'(brake_pkg::OV_FILTER_CYC - 1))
    else $error("overvoltage brake ended before the release filter time");

  c_slam_fault: cover property ((fault_reg & ~$past(fault_reg)) != '0 && slam_req);
  c_ov_cycle: cover property ($fell(ov_active_reg) && ovstat_reg == 2'h3);
  c_recover: cover property ($fell(fault_reg != '0) ##[0:20] lowside_on_reg != '0);

endmodule
`default_nettype wire

// file: logic/brake_pkg.sv
// Constants and types for the low-side brake supervisor
package brake_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int LS_COUNT         = 4;
  localparam int BLANK_ONE_NS     = 2000;
  localparam int BLANK_TWO_NS     = 8000;
  localparam int VDS_FILTER_NS    = 1000;
  localparam int OV_FILTER_NS     = 4000;
  // Least times round up to whole cycles
  localparam int BLANK_ONE_CYC    = (BLANK_ONE_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_TWO_CYC    = (BLANK_TWO_NS * CLK_MHZ + 999) / 1000;
  localparam int VDS_FILTER_CYC   = (VDS_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int OV_FILTER_CYC    = (OV_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W          = 12;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] OV_LEVEL_RESET = 3'h0;
  localparam logic       SEL_FIRST      = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_BLANK   = 2'b01,
    ST_MONITOR = 2'b10
  } brake_state_t;

endpackage

// file: logic/persist_filter.sv
// Persistence filter: flags a condition held for a set number of cycles
`timescale 1ns/10ps
`default_nettype none
module persist_filter #(
  parameter int COUNT   = 4,
  parameter int COUNT_W = 12
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic cond,
  output var  logic hit
);

  localparam logic [COUNT_W-1:0] LIMIT = COUNT_W'(COUNT);

  logic [COUNT_W-1:0] cnt_reg;

  generate
    if (COUNT < 1 || COUNT >= (1 << COUNT_W)) begin : g_bad
      $error("persist_filter: COUNT does not fit COUNT_W");
    end
  endgenerate

  // Saturating run-length counter; any gap restarts the run
  always_ff @(posedge clk) begin
    if (rst || !enable || !cond) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + COUNT_W'(1);
    end
  end

  assign hit = enable && cond && (cnt_reg == LIMIT - COUNT_W'(1));

endmodule
`default_nettype wire

// file: verification/mosfet_bridge_model.sv
// External low-side MOSFET model feeding the drain-source comparators
`timescale 1ns/10ps
`default_nettype none
module mosfet_bridge_model #(
  parameter int LS_N = 4
) (
  input  wire logic [LS_N-1:0] gate_on,
  input  wire logic [LS_N-1:0] short_one,
  input  wire logic [LS_N-1:0] short_two,
  output var  logic [LS_N-1:0] vds_over_one,
  output var  logic [LS_N-1:0] vds_over_two
);
  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // An off low side sees the motor node near supply, so both read high
  always_comb begin
    vds_over_two = ~gate_on | short_two;
    vds_over_one = ~gate_on | short_one | short_two;
  end
endmodule
`default_nettype wire

// file: verification/brake_lowside_vds_supervisor_bench.sv
// Self-checking bench for the low-side brake supervisor
`timescale 1ns/10ps
`default_nettype none
module brake_lowside_vds_supervisor_bench;
  typedef struct {logic [14:0] s; int lo; int hi;} note_t;
  logic        ref_clk, rst, slam_en, trig, park_en, sleep, ov_en, m_over, i_over;
  logic        m_hys, i_hys, th_sel, blk_sel, pump_en, pump_on, active, m_st, i_st;
  logic [3:0]  dis, clr, sh_one, sh_two, lson, flt, vds1, vds2;
  logic [2:0]  lvl, lvl_code;
  logic [1:0]  st_clr;
  logic [14:0] snap, prev;
  logic [31:0] seed;
  note_t       q[$];
  note_t       n;
  int          cyc = 0;
  int          n_mismatch = 0;
  int          num_checks = 0;
  bit          mon_on = 1'b0;

  assign snap = {lvl_code, m_st, i_st, flt, active, pump_on, lson};

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  brake_lowside_vds_supervisor #(.LS_N(4)) i_brake_lowside_vds_supervisor (
    .REF_CLK(ref_clk), .RST(rst), .SLAM_ENABLE(slam_en), .SLAM_TRIGGER_INPUT(trig),
    .SLAM_LOWSIDE_DISABLE(dis), .PARKING_BRAKE_ENABLE(park_en), .SLEEP_OR_STOP(sleep),
    .OVERVOLTAGE_BRAKE_ENABLE(ov_en), .OV_LEVEL_SELECT(lvl), .MAIN_SUPPLY_OVER(m_over),
    .INTERNAL_SUPPLY_OVER(i_over), .MAIN_SUPPLY_BELOW_HYS(m_hys),
    .INTERNAL_SUPPLY_BELOW_HYS(i_hys), .BRAKE_VDS_THRESHOLD_SELECT(th_sel),
    .BRAKE_BLANK_TIME_SELECT(blk_sel), .VDS_OVER_TH_ONE(vds1), .VDS_OVER_TH_TWO(vds2),
    .FAULT_CLEAR(clr), .OVBRAKE_STATUS_CLEAR(st_clr), .CHARGE_PUMP_ENABLE(pump_en),
    .LOWSIDE_ON(lson), .CHARGE_PUMP_ON(pump_on), .BRAKE_ACTIVE(active),
    .LOWSIDE_BRAKE_VDS_FAULT(flt), .MAIN_SUPPLY_OVBRAKE_STATUS(m_st),
    .INTERNAL_SUPPLY_OVBRAKE_STATUS(i_st), .OV_LEVEL_CODE(lvl_code));

  mosfet_bridge_model #(.LS_N(4)) i_mosfet_bridge_model (
    .gate_on(lson), .short_one(sh_one), .short_two(sh_two),
    .vds_over_one(vds1), .vds_over_two(vds2));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic miss(input string what, input logic [31:0] e, input logic [31:0] s);
    $display("ERROR %s expected %h seen %h", what, e, s);
    n_mismatch++;
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  // Note an expected output picture and the cycle window it must land in
  task automatic ex(input logic [2:0] l, input logic m, i, input logic [3:0] f,
                    input logic a, p, input logic [3:0] ls, input int lo, hi);
    q.push_back('{{l, m, i, f, a, p, ls}, cyc + lo, cyc + hi});
  endtask

  // Bounded wait until every noted change has shown up
  task automatic settle;
    int k;
    for (k = 0; k < 3000 && q.size() > 0; k++) @(negedge ref_clk);
    if (q.size() > 0) begin
      miss("timeout", 0, q.size());
      end_sim();
    end else begin
      tick(4);
    end
  endtask

  // Any change of the outputs must match the oldest note, in its window
  always @(negedge ref_clk) begin
    if (mon_on && snap !== prev) begin
      num_checks++;
      if (q.size() == 0) miss("unexpected", prev, snap);
      else begin
        n = q.pop_front();
        if (n.s !== snap) miss("outputs", n.s, snap);
        if (cyc < n.lo || cyc > n.hi) miss("cycle", n.lo, cyc);
      end
    end
    prev = snap;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst, slam_en, trig, park_en, sleep, ov_en, m_over, i_over} = 8'h80;
    {m_hys, i_hys, th_sel, blk_sel, pump_en} = 5'h0;
    {dis, clr, sh_one, sh_two, lvl, st_clr} = 21'h0;
    seed = 32'hf157da94;
    tick(12);
    rst = 1'b0;
    tick(1);
    num_checks++;
    if (snap !== 15'h0) miss("reset", 15'h0, snap);
    mon_on = 1'b1;
    // Slam braking with a shorted low side, pump requested until the fault clear
    pump_en = 1'b1;
    ex(3'h0, 0, 0, 4'h0, 0, 1, 4'h0, 1, 2);
    settle();
    seed = lfsr(seed);
    dis = seed[3:0] & 4'h5;
    {slam_en, trig, sh_one} = 6'h32;
    ex(3'h0, 0, 0, 4'h0, 1, 0, ~dis, 1, 1);
    ex(3'h0, 0, 0, 4'h2, 0, 0, 4'h0, 750, 752);
    settle();
    tick(30);
    {pump_en, sh_one, clr} = 9'h002;
    ex(3'h0, 0, 0, 4'h0, 1, 0, ~dis, 1, 1);
    tick(1);
    clr = 4'h0;
    settle();
    trig = 1'b0;
    ex(3'h0, 0, 0, 4'h0, 0, 0, 4'h0, 1, 1);
    settle();
    // Parking brake, second blank and second threshold
    {slam_en, park_en, blk_sel, th_sel, sh_one, sh_two} = 12'h718;
    tick(20);
    sleep = 1'b1;
    ex(3'h0, 0, 0, 4'h0, 1, 0, 4'hf, 1, 1);
    ex(3'h0, 0, 0, 4'h8, 0, 0, 4'h0, 2250, 2252);
    settle();
    sleep = 1'b0;
    tick(20);
    pump_en = 1'b1;
    tick(20);
    {pump_en, sh_one, sh_two, clr} = 13'h000f;
    ex(3'h0, 0, 0, 4'h0, 0, 0, 4'h0, 1, 1);
    tick(1);
    {clr, pump_en} = 5'h01;
    ex(3'h0, 0, 0, 4'h0, 0, 1, 4'h0, 1, 2);
    settle();
    {pump_en, park_en, blk_sel, th_sel} = 4'h0;
    ex(3'h0, 0, 0, 4'h0, 0, 0, 4'h0, 1, 2);
    settle();
    // Supply overvoltage braking at a random level
    seed = lfsr(seed);
    lvl = (seed[2:0] == 3'h0) ? 3'h7 : seed[2:0];
    ex(lvl, 0, 0, 4'h0, 0, 0, 4'h0, 1, 1);
    settle();
    m_over = 1'b1;
    tick(20);
    ov_en = 1'b1;
    ex(lvl, 1, 0, 4'h0, 1, 0, 4'hf, 1, 1);
    settle();
    i_over = 1'b1;
    ex(lvl, 1, 1, 4'h0, 1, 0, 4'hf, 1, 1);
    tick(1);
    i_over = 1'b0;
    settle();
    {m_over, m_hys} = 2'h1;
    tick(1100);
    i_hys = 1'b1;
    ex(lvl, 1, 1, 4'h0, 0, 0, 4'h0, 1000, 1002);
    settle();
    st_clr = 2'h3;
    ex(lvl, 0, 0, 4'h0, 0, 0, 4'h0, 1, 1);
    tick(1);
    st_clr = 2'h0;
    settle();
    end_sim();
  end
endmodule
`default_nettype wire
